// file: src/mtig_event_gen.sv
`timescale 1ns/10ps
`default_nettype none

module mtig_event_gen
  import mtig_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // settings
  input  wire mtig_pkg::mtig_config_t       i_config,
  input  wire logic [mtig_pkg::AXIS_W-1:0]  i_threshold,
  input  wire logic [mtig_pkg::CNT_W-1:0]   i_min_duration,
  input  wire logic                         i_latch,
  // samples
  input  wire logic                         i_sample_valid,
  input  wire mtig_pkg::mtig_axes_t         i_sample,
  // source register
  input  wire logic                         i_source_read,
  output logic [7:0]                        o_source,
  output logic                              o_active
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             active;
    mtig_events_t     flags;
  } mtig_gen_state_t;

  mtig_gen_state_t q;
  mtig_gen_state_t next_q;
  mtig_events_t    raw;
  mtig_events_t    en;
  logic            cond;
  logic            recog;

  function automatic logic [1:0] compare(input logic [AXIS_W-1:0] s,
                                         input logic [AXIS_W-1:0] t);
    compare = {s > t, s < t};
  endfunction

  always_comb
  begin
    en     = i_config.enable;
    raw    = {compare(i_sample.z, i_threshold), compare(i_sample.y, i_threshold),
              compare(i_sample.x, i_threshold)} & en;
    if (i_config.event_combine_select)
      cond = (|en) && ((raw | ~en) == ALL_EVENTS);
    else
      cond = |raw;
    recog  = i_sample_valid && cond && (q.cnt >= i_min_duration);
    next_q = q;
    if (i_sample_valid)
    begin
      if (!cond)
        next_q.cnt = '0;
      else if (q.cnt != CNT_MAX)
        next_q.cnt = q.cnt + 1'b1;
    end
    if (i_source_read)
    begin
      next_q.active = 1'b0;
      if (i_latch)
        next_q.flags = '0;
    end
    if (i_latch)
    begin
      if (recog)
      begin
        next_q.active = 1'b1;
        if (!q.active || i_source_read)
          next_q.flags = raw;
      end
    end
    else if (i_sample_valid)
    begin
      if (recog)
        next_q.active = 1'b1;
      else if (!q.active || i_source_read || !cond)
        next_q.active = 1'b0;
      next_q.flags = cond ? raw : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign o_source = {1'b0, q.active, q.flags};
  assign o_active = q.active;

  property p_read_clears;
    @(posedge clk) disable iff (!rst_n)
      (i_source_read && !recog) |=> !q.active;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear active");

  property p_no_enable_quiet;
    @(posedge clk) disable iff (!rst_n)
      (en == '0 && !q.active) |=> !q.active;
  endproperty
  a_no_enable_quiet: assert property (p_no_enable_quiet) else $error("set while disabled");

  property p_high_event;
    @(posedge clk) disable iff (!rst_n)
      (i_sample_valid && en.x_high && i_sample.x > i_threshold
       && !i_config.event_combine_select && i_min_duration == '0 && !i_latch)
      |=> (q.active && q.flags.x_high);
  endproperty
  a_high_event: assert property (p_high_event) else $error("x high event missed");

  property p_low_event;
    @(posedge clk) disable iff (!rst_n)
      (i_sample_valid && en.y_low && i_sample.y < i_threshold
       && !i_config.event_combine_select && i_min_duration == '0 && !i_latch)
      |=> (q.active && q.flags.y_low);
  endproperty
  a_low_event: assert property (p_low_event) else $error("y low event missed");

  property p_and_needs_all;
    @(posedge clk) disable iff (!rst_n)
      (i_sample_valid && i_config.event_combine_select && en.x_low && en.z_high
       && !(i_sample.z > i_threshold) && !q.active && !i_latch) |=> !q.active;
  endproperty
  a_and_needs_all: assert property (p_and_needs_all) else $error("and mode fired early");

  property p_duration;
    @(posedge clk) disable iff (!rst_n)
      (!q.active && $rose(next_q.active)) |-> (q.cnt >= i_min_duration);
  endproperty
  a_duration: assert property (p_duration) else $error("active before duration");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n)
      (i_latch && q.active && !i_source_read) |=> (q.active && $stable(q.flags));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched source changed");

endmodule

`default_nettype wire

// file: src/mtig_pkg.sv
package mtig_pkg;

  localparam int unsigned AXIS_W = 7;
  localparam int unsigned CNT_W  = 7;

  // register offsets
  localparam logic [7:0] OFS_GEN1_CONFIG       = 8'h30;
  localparam logic [7:0] OFS_GEN1_SOURCE       = 8'h31;
  localparam logic [7:0] OFS_GEN1_THRESHOLD    = 8'h32;
  localparam logic [7:0] OFS_GEN1_MIN_DURATION = 8'h33;
  localparam logic [7:0] OFS_GEN2_CONFIG       = 8'h34;
  localparam logic [7:0] OFS_GEN2_SOURCE       = 8'h35;
  localparam logic [7:0] OFS_GEN2_THRESHOLD    = 8'h36;
  localparam logic [7:0] OFS_GEN2_MIN_DURATION = 8'h37;
  localparam logic [5:0] OFS_BLOCK_MASK        = 6'h0c;
  localparam logic [1:0] KIND_CONFIG           = 2'h0;
  localparam logic [1:0] KIND_SOURCE           = 2'h1;
  localparam logic [1:0] KIND_THRESHOLD        = 2'h2;
  localparam logic [1:0] KIND_MIN_DURATION     = 2'h3;

  // field positions
  localparam int unsigned POS_COMBINE     = 7;
  localparam int unsigned POS_ACTIVE_FLAG = 6;

  // reset values, counter limit and event mask
  localparam logic [7:0]       RST_CONFIG = 8'h00;
  localparam logic [AXIS_W-1:0] RST_THRESHOLD = 7'h00;
  localparam logic [CNT_W-1:0]  RST_DURATION  = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_MAX       = 7'h7f;
  localparam logic [5:0]        ALL_EVENTS    = 6'h3f;

  // pin routing codes
  localparam logic [1:0] ROUTE_OWN        = 2'h0;
  localparam logic [1:0] ROUTE_BOTH       = 2'h1;
  localparam logic [1:0] ROUTE_DATA_READY = 2'h2;
  localparam logic [1:0] ROUTE_BOOT       = 2'h3;

  typedef struct packed {
    logic [AXIS_W-1:0] z;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] x;
  } mtig_axes_t;

  // bit order of config enables and source flags
  typedef struct packed {
    logic z_high;
    logic z_low;
    logic y_high;
    logic y_low;
    logic x_high;
    logic x_low;
  } mtig_events_t;

  typedef struct packed {
    logic         event_combine_select;
    logic         reserved;
    mtig_events_t enable;
  } mtig_config_t;

  typedef struct packed {
    logic             hit;
    logic             gen;
    logic [1:0]       kind;
  } mtig_sel_t;

endpackage

// file: src/mtig_top.sv
`timescale 1ns/10ps
`default_nettype none

module mtig_top
  import mtig_pkg::*;
(
  // clock and reset
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_RESETN,
  // register port
  input  wire logic                   I_REG_WR,
  input  wire logic                   I_REG_RD,
  input  wire logic [7:0]             I_REG_ADDR,
  input  wire logic [7:0]             I_REG_WDATA,
  output logic [7:0]                  O_REG_RDATA,
  // samples
  input  wire logic                   I_SAMPLE_VALID,
  input  wire mtig_pkg::mtig_axes_t   I_SAMPLE,
  // settings and status held elsewhere in the device
  input  wire logic                   I_LATCH_SELECT_ONE,
  input  wire logic                   I_LATCH_SELECT_TWO,
  input  wire logic [1:0]             I_PIN_ONE_ROUTE_SELECT,
  input  wire logic [1:0]             I_PIN_TWO_ROUTE_SELECT,
  input  wire logic                   I_DATA_READY,
  input  wire logic                   I_BOOT_RUNNING,
  // interrupt pins
  output logic                        O_EVENT_PIN_ONE,
  output logic                        O_EVENT_PIN_TWO
);

  typedef struct packed {
    logic [1:0][7:0]        config_reg;
    logic [1:0][AXIS_W-1:0] threshold;
    logic [1:0][CNT_W-1:0]  min_duration;
    logic [7:0]             rdata;
    logic                   pin_one;
    logic                   pin_two;
  } mtig_top_state_t;

  mtig_top_state_t q;
  mtig_top_state_t next_q;
  logic [1:0]      rst_sync;
  logic            rst_n;
  mtig_sel_t       sel;
  logic [1:0]      src_read;
  logic [1:0][7:0] source;
  logic [1:0]      active;
  logic [1:0]      latch;
  logic [1:0][1:0] route;

  function automatic mtig_sel_t decode(input logic [7:0] addr);
    mtig_sel_t s;
    s.hit  = (addr[7:2] == OFS_GEN1_CONFIG[7:2]) || (addr[7:2] == OFS_GEN2_CONFIG[7:2]);
    s.gen  = (addr[7:2] == OFS_GEN2_CONFIG[7:2]);
    s.kind = addr[1:0];
    return s;
  endfunction

  function automatic logic route_pin(input logic [1:0] r, input logic own,
                                     input logic both, input logic drdy,
                                     input logic boot);
    case (r)
      ROUTE_OWN:        route_pin = own;
      ROUTE_BOTH:       route_pin = both;
      ROUTE_DATA_READY: route_pin = drdy;
      ROUTE_BOOT:       route_pin = boot;
      default:          route_pin = own;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  assign sel   = decode(I_REG_ADDR);
  assign latch = {I_LATCH_SELECT_TWO, I_LATCH_SELECT_ONE};
  assign route = {I_PIN_TWO_ROUTE_SELECT, I_PIN_ONE_ROUTE_SELECT};

  always_comb
  begin
    src_read = 2'b00;
    if (I_REG_RD && sel.hit && sel.kind == KIND_SOURCE)
      src_read[sel.gen] = 1'b1;
  end

  for (genvar g = 0; g < 2; g++)
  begin : gen_event
    mtig_event_gen u_gen (
      .clk            (I_CLOCK),
      .rst_n          (rst_n),
      .i_config       (mtig_config_t'(q.config_reg[g])),
      .i_threshold    (q.threshold[g]),
      .i_min_duration (q.min_duration[g]),
      .i_latch        (latch[g]),
      .i_sample_valid (I_SAMPLE_VALID),
      .i_sample       (I_SAMPLE),
      .i_source_read  (src_read[g]),
      .o_source       (source[g]),
      .o_active       (active[g])
    );
  end

  always_comb
  begin
    next_q = q;
    if (I_REG_WR && sel.hit)
    begin
      case (sel.kind)
        KIND_CONFIG:
        begin
          next_q.config_reg[sel.gen] = I_REG_WDATA;
          next_q.config_reg[sel.gen][POS_ACTIVE_FLAG] = 1'b0;
        end
        KIND_THRESHOLD:    next_q.threshold[sel.gen] = I_REG_WDATA[AXIS_W-1:0];
        KIND_MIN_DURATION: next_q.min_duration[sel.gen] = I_REG_WDATA[CNT_W-1:0];
        default:           next_q.threshold = q.threshold;
      endcase
    end
    next_q.rdata = 8'h00;
    if (I_REG_RD && sel.hit)
    begin
      case (sel.kind)
        KIND_CONFIG:       next_q.rdata = q.config_reg[sel.gen];
        KIND_SOURCE:       next_q.rdata = source[sel.gen];
        KIND_THRESHOLD:    next_q.rdata = {1'b0, q.threshold[sel.gen]};
        KIND_MIN_DURATION: next_q.rdata = {1'b0, q.min_duration[sel.gen]};
        default:           next_q.rdata = 8'h00;
      endcase
    end
    next_q.pin_one = route_pin(route[0], active[0], |active, I_DATA_READY,
                               I_BOOT_RUNNING);
    next_q.pin_two = route_pin(route[1], active[1], |active, I_DATA_READY,
                               I_BOOT_RUNNING);
  end

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q              <= '0;
      q.config_reg   <= {RST_CONFIG, RST_CONFIG};
      q.threshold    <= {RST_THRESHOLD, RST_THRESHOLD};
      q.min_duration <= {RST_DURATION, RST_DURATION};
    end
    else
      q <= next_q;
  end

  assign O_REG_RDATA     = q.rdata;
  assign O_EVENT_PIN_ONE = q.pin_one;
  assign O_EVENT_PIN_TWO = q.pin_two;

  property p_pin_route;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[0] == ROUTE_OWN && $stable(route[0])) |-> (O_EVENT_PIN_ONE == $past(active[0]));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin one not own status");

  property p_pin_or;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[1] == ROUTE_BOTH) |=> (O_EVENT_PIN_TWO == $past(|active));
  endproperty
  a_pin_or: assert property (p_pin_or) else $error("pin two not or of both");

  property p_read_drops_pin;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (src_read[0] && route[0] == ROUTE_OWN && !I_SAMPLE_VALID) ##1 (route[0] == ROUTE_OWN)
      |=> !O_EVENT_PIN_ONE;
  endproperty
  a_read_drops_pin: assert property (p_read_drops_pin) else $error("pin stuck after read");

  property p_reserved_zero;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && sel.hit && sel.kind != KIND_CONFIG) |=> (O_REG_RDATA[7] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read 1");

  property p_source_ro;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_WR && sel.hit && sel.kind == KIND_SOURCE && !I_SAMPLE_VALID && !I_REG_RD)
      |=> $stable(source);
  endproperty
  a_source_ro: assert property (p_source_ro) else $error("source changed by write");

  property p_config_bit6;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && sel.hit && sel.kind == KIND_CONFIG) |=> !O_REG_RDATA[POS_ACTIVE_FLAG];
  endproperty
  a_config_bit6: assert property (p_config_bit6) else $error("config bit 6 read 1");

  property p_source_snapshot;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && sel.hit && sel.kind == KIND_SOURCE)
      |=> (O_REG_RDATA == $past(source[sel.gen]));
  endproperty
  a_source_snapshot: assert property (p_source_snapshot) else $error("source read wrong");

  property p_threshold_write;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_WR && sel.hit && sel.kind == KIND_THRESHOLD)
      |=> (q.threshold[$past(sel.gen)] == $past(I_REG_WDATA[AXIS_W-1:0]));
  endproperty
  a_threshold_write: assert property (p_threshold_write) else $error("threshold lost");

  property p_duration_write;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_WR && sel.hit && sel.kind == KIND_MIN_DURATION)
      |=> (q.min_duration[$past(sel.gen)] == $past(I_REG_WDATA[CNT_W-1:0]));
  endproperty
  a_duration_write: assert property (p_duration_write) else $error("duration lost");

  property p_enable_write;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_WR && sel.hit && sel.kind == KIND_CONFIG)
      |=> (q.config_reg[$past(sel.gen)][5:0] == $past(I_REG_WDATA[5:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enables lost");

  property p_gen_independent;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_WR && sel.hit && !sel.gen) |=> $stable(q.config_reg[1]);
  endproperty
  a_gen_independent: assert property (p_gen_independent) else $error("gen two disturbed");

  property p_unmapped_read;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && !sel.hit) |=> (O_REG_RDATA == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_pin_one_ready;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[0] == ROUTE_DATA_READY) |=> (O_EVENT_PIN_ONE == $past(I_DATA_READY));
  endproperty
  a_pin_one_ready: assert property (p_pin_one_ready) else $error("pin one not data ready");

  property p_pin_two_boot;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[1] == ROUTE_BOOT) |=> (O_EVENT_PIN_TWO == $past(I_BOOT_RUNNING));
  endproperty
  a_pin_two_boot: assert property (p_pin_two_boot) else $error("pin two not boot");

  property p_pin_two_own;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[1] == ROUTE_OWN) |=> (O_EVENT_PIN_TWO == $past(active[1]));
  endproperty
  a_pin_two_own: assert property (p_pin_two_own) else $error("pin two not own status");

  property p_pin_one_both;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (route[0] == ROUTE_BOTH) |=> (O_EVENT_PIN_ONE == $past(|active));
  endproperty
  a_pin_one_both: assert property (p_pin_one_both) else $error("pin one not or of both");

  property p_read_clears_two;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (src_read[1] && !I_SAMPLE_VALID) |=> !active[1];
  endproperty
  a_read_clears_two: assert property (p_read_clears_two) else $error("gen two active");

  property p_threshold_read;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && sel.hit && sel.kind == KIND_THRESHOLD)
      |=> (O_REG_RDATA[AXIS_W-1:0] == $past(q.threshold[sel.gen]));
  endproperty
  a_threshold_read: assert property (p_threshold_read) else $error("threshold read wrong");

  property p_duration_read;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RD && sel.hit && sel.kind == KIND_MIN_DURATION)
      |=> (O_REG_RDATA[CNT_W-1:0] == $past(q.min_duration[sel.gen]));
  endproperty
  a_duration_read: assert property (p_duration_read) else $error("duration read wrong");

  property p_latch_release;
    @(posedge I_CLOCK) disable iff (!rst_n)
      (src_read[1] && latch[1] && !I_SAMPLE_VALID) |=> (source[1] == 8'h00);
  endproperty
  a_latch_release: assert property (p_latch_release) else $error("held source kept");

endmodule

`default_nettype wire

// file: tb/mtig_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module mtig_host_model
(
  // clock
  input  wire logic       clk,
  // register port
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);

  initial
  begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // one-cycle write strobe, never together with a read
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // one-cycle read strobe, answer checked by the bench
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
  endtask

endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import mtig_pkg::*;

  logic             clk;
  logic             rst_n;
  logic             wr;
  logic             rd;
  logic [7:0]       addr;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic             smp_v;
  mtig_axes_t       smp;
  logic             latch1;
  logic             latch2;
  logic [1:0]       route1;
  logic [1:0]       route2;
  logic             drdy;
  logic             boot;
  logic             pin1;
  logic             pin2;
  logic             rd_seen;
  logic [7:0]       exp_q[$];
  int               mismatches;
  int               checks_done;
  int               cycles;
  integer           seed;
  int               i;
  logic [7:0]       raw;
  logic [6:0]       x;
  logic [6:0]       y;
  logic [6:0]       z;
  logic [5:0]       f;

  mtig_host_model u_mtig_host_model (
    .clk     (clk),
    .o_wr    (wr),
    .o_rd    (rd),
    .o_addr  (addr),
    .o_wdata (wdata)
  );

  mtig_top u_mtig_top (
    .I_CLOCK                (clk),
    .I_RESETN               (rst_n),
    .I_REG_WR               (wr),
    .I_REG_RD               (rd),
    .I_REG_ADDR             (addr),
    .I_REG_WDATA            (wdata),
    .O_REG_RDATA            (rdata),
    .I_SAMPLE_VALID         (smp_v),
    .I_SAMPLE               (smp),
    .I_LATCH_SELECT_ONE     (latch1),
    .I_LATCH_SELECT_TWO     (latch2),
    .I_PIN_ONE_ROUTE_SELECT (route1),
    .I_PIN_TWO_ROUTE_SELECT (route2),
    .I_DATA_READY           (drdy),
    .I_BOOT_RUNNING         (boot),
    .O_EVENT_PIN_ONE        (pin1),
    .O_EVENT_PIN_TWO        (pin2)
  );

  always #2.5 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp1(input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_mtig_host_model.wr(a, d);
  endtask

  // note the expected read data, then issue the read
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_mtig_host_model.rd(a);
  endtask

  task automatic sample(input logic [6:0] zz, input logic [6:0] yy, input logic [6:0] xx);
    @(posedge clk);
    smp_v <= 1'b1;
    smp   <= {zz, yy, xx};
    @(posedge clk);
    smp_v <= 1'b0;
  endtask

  // pins settle two edges after a sample or read
  task automatic pins(input logic e1, input logic e2);
    repeat (2) @(posedge clk);
    cmp1(e1, pin1);
    cmp1(e2, pin2);
  endtask

  // read data watcher, one cycle after each read strobe
  always @(posedge clk)
  begin
    if (rd_seen && exp_q.size() != 0)
      cmp8(exp_q.pop_front(), rdata);
    rd_seen <= rd;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    seed = 96941;
    clk = 1'b0;
    rst_n = 1'b0;
    smp_v = 1'b0;
    smp = '0;
    latch1 = 1'b0;
    latch2 = 1'b0;
    route1 = 2'h0;
    route2 = 2'h0;
    drdy = 1'b0;
    boot = 1'b0;
    rd_seen = 1'b0;
    cycles = 0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    sample(7'h7f, 7'h7f, 7'h7f);
    sample(7'h00, 7'h00, 7'h00);
    pins(1'b0, 1'b0);
    for (i = 8'h30; i <= 8'h38; i++)
      rd_exp(8'(i), 8'h00);
    wr_reg(8'h34, 8'hff);
    wr_reg(8'h36, 8'hff);
    wr_reg(8'h37, 8'hff);
    wr_reg(8'h35, 8'hff);
    wr_reg(8'h31, 8'hff);
    rd_exp(8'h34, 8'hbf);
    rd_exp(8'h36, 8'h7f);
    rd_exp(8'h37, 8'h7f);
    rd_exp(8'h35, 8'h00);
    rd_exp(8'h31, 8'h00);
    rd_exp(8'h30, 8'h00);
    // random thresholds and samples, all six events ORed
    wr_reg(8'h30, 8'h3f);
    for (i = 0; i < 16; i++)
    begin
      raw = 8'($random(seed));
      x = 7'($random(seed));
      y = 7'($random(seed));
      z = 7'($random(seed));
      if (i % 4 == 0)
        x = raw[6:0];
      wr_reg(8'h32, raw);
      sample(z, y, x);
      f = {z > raw[6:0], z < raw[6:0], y > raw[6:0], y < raw[6:0], x > raw[6:0], x < raw[6:0]};
      pins(|f, 1'b0);
      rd_exp(8'h31, {1'b0, |f, f});
      pins(1'b0, 1'b0);
    end
    // minimum duration of two steps on x high
    wr_reg(8'h30, 8'h02);
    wr_reg(8'h32, 8'h0a);
    wr_reg(8'h33, 8'h02);
    sample(7'h00, 7'h00, 7'h00);
    for (i = 0; i < 6; i++)
    begin
      sample(7'h00, 7'h00, (i == 2) ? 7'h0a : 7'h0b);
      pins(i == 5, 1'b0);
    end
    rd_exp(8'h31, 8'h42);
    pins(1'b0, 1'b0);
    // both x high and y high needed, pin two routes both
    route2 <= 2'h1;
    wr_reg(8'h33, 8'h00);
    wr_reg(8'h30, 8'h8a);
    sample(7'h00, 7'h05, 7'h14);
    pins(1'b0, 1'b0);
    sample(7'h00, 7'h14, 7'h14);
    pins(1'b1, 1'b1);
    rd_exp(8'h31, 8'h4a);
    pins(1'b0, 1'b0);
    // second generator latched, pin one routes both
    latch2 <= 1'b1;
    route1 <= 2'h1;
    route2 <= 2'h0;
    wr_reg(8'h34, 8'h10);
    wr_reg(8'h36, 8'h14);
    wr_reg(8'h37, 8'h00);
    sample(7'h05, 7'h00, 7'h00);
    pins(1'b1, 1'b1);
    sample(7'h32, 7'h00, 7'h00);
    pins(1'b1, 1'b1);
    rd_exp(8'h35, 8'h50);
    pins(1'b0, 1'b0);
    sample(7'h05, 7'h00, 7'h00);
    pins(1'b1, 1'b1);
    rd_exp(8'h35, 8'h50);
    pins(1'b0, 1'b0);
    route1 <= 2'h2;
    route2 <= 2'h3;
    for (i = 0; i < 4; i++)
    begin
      drdy <= i[0];
      boot <= i[1];
      pins(i[0], i[1]);
    end
    tally_and_finish();
  end

endmodule

`default_nettype wire
